// *** mcid_pkg.sv ***
`default_nettype none
package mcid_pkg;
  // ---------------------------------------------------------------
  // register bus map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // run, gie, prescaler owner
  localparam logic [7:0] REG_CORE = 8'h04; // pc, state, accumulator
  localparam logic [7:0] REG_FLAGS = 8'h08; // timer, status byte
  localparam int CTRL_RUN = 0;
  localparam int CTRL_GIE = 1;
  localparam int CTRL_PS_TMR = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // instruction classes and opcodes
  // ---------------------------------------------------------------
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_CTRL = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  localparam logic [6:0] FIX_RETURN = 7'h08;
  localparam logic [6:0] FIX_RETFIE = 7'h09;
  localparam logic [6:0] FIX_SLEEP = 7'h63;
  localparam logic [6:0] FIX_CLRWDT = 7'h64;
  // ---------------------------------------------------------------
  // data memory and special locations
  // ---------------------------------------------------------------
  localparam logic [6:0] F_TIMER = 7'h01;
  localparam logic [6:0] F_PCL = 7'h02;
  localparam logic [6:0] F_STATUS = 7'h03;
  localparam logic [6:0] F_PORT = 7'h06;
  localparam logic [6:0] F_PROGRAM_COUNTER_UPPER_LATCH = 7'h0a;
  localparam logic [6:0] SHARED_BASE = 7'h70; // top 16 of each bank
  localparam int RAM_WORDS = 512;
  localparam int STACK_DEPTH = 8;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam int ST_RP0 = 5;
  localparam int ST_RP1 = 6;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {MCID_EXEC, MCID_FLUSH, MCID_SLEEP} mcid_state_t;
  typedef struct packed {
    logic [1:0] cls;
    logic [3:0] op;
    logic dest;
    logic [2:0] bitpos;
    logic [6:0] f;
    logic [7:0] lit;
    logic [10:0] target;
  } mcid_dec_t;
endpackage
`default_nettype wire

// *** mcid_core.sv ***
// How it works
// - interrupt stacks only the return address
// - top 16 bytes shared across all banks
// - class 00: op, destination bit, location
// - class 01: bit clear or set
// - bit tests skip, flags untouched
// - rotates through carry, only carry changes
// - and, or, xor with register set zero
// - decrement or increment, skip on zero
// - literal and, or, xor set zero
// - literal subtract and add set three flags
// - literal return loads accumulator, two cycles
// - standby word sets timeout flag and clears powerdown flag
// - class 10: call or jump, two cycles
// - pc write or taken skip adds flush cycle
// - port reads use pin levels
// - timer write clears assigned prescaler
`timescale 1ns/1ns
`default_nettype none
module mcid_core (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // register bus read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // program memory
  output logic [12:0] prog_addr,
  input wire logic [13:0] prog_word,
  // pins
  input wire logic [7:0] port_pins,
  output logic [7:0] port_latch,
  input wire logic irq_pin,
  output logic sleeping
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mcid_pkg::mcid_state_t state, next_state; // sequencer
  logic [12:0] pc, next_pc; // program counter
  logic [7:0] acc, next_acc; // accumulator
  logic [7:0] status, next_status; // flags and bank select
  logic [4:0] program_counter_upper_latch, next_program_counter_upper_latch; // upper pc latch
  logic [7:0] latch, next_latch; // port output latch
  logic [7:0] tmr, next_tmr; // timer zero count
  logic [7:0] pre, next_pre; // prescaler
  logic [2:0] sp, next_sp; // stack pointer
  logic irq_act, next_irq_act; // in service routine
  logic [12:0] stack [mcid_pkg::STACK_DEPTH]; // return addresses
  logic [7:0] ram [mcid_pkg::RAM_WORDS]; // banked data memory
  logic push; // stack write
  logic [12:0] push_val; // value pushed
  logic ram_we; // data memory write
  logic [7:0] res; // result byte
  logic wr_f, wr_acc; // result targets
  logic upd_z, upd_c, upd_dc; // flag updates
  logic c_val; // new carry
  logic [2:0] ctrl; // software control bits
  logic [7:0] pin_s1, pin_s2; // port synchroniser
  logic irq_s1, irq_s2; // interrupt synchroniser
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // map bank and location to a memory word
  function automatic logic [8:0] mem_index(input logic [1:0] bank,
                                           input logic [6:0] f);
    if (f >= mcid_pkg::SHARED_BASE)
      mem_index = {2'h0, f};
    else
      mem_index = {bank, f};
  endfunction

  // split the word into fields
  function automatic mcid_pkg::mcid_dec_t decode(input logic [13:0] w);
    decode.cls = w[13:12];
    decode.op = w[11:8];
    decode.dest = w[7];
    decode.bitpos = w[9:7];
    decode.f = w[6:0];
    decode.lit = w[7:0];
    decode.target = w[10:0];
  endfunction

  mcid_pkg::mcid_dec_t dec;
  logic [8:0] ridx; // data memory index
  logic [7:0] fval; // operand byte
  logic is_sub; // adder subtracts accumulator
  logic [7:0] ax; // adder left operand
  logic [8:0] sum; // adder with carry out
  logic [4:0] nib; // low nibble sum
  logic run, take_irq, exec; // sequencing terms

  assign dec = decode(prog_word);
  assign ridx = mem_index(status[mcid_pkg::ST_RP1:mcid_pkg::ST_RP0], dec.f);
  assign run = ctrl[mcid_pkg::CTRL_RUN];
  assign take_irq = irq_s2 && ctrl[mcid_pkg::CTRL_GIE] && !irq_act;
  assign exec = state == mcid_pkg::MCID_EXEC && run && !take_irq;
  assign is_sub = (dec.cls == mcid_pkg::CLS_BYTE && dec.op == 4'h2) ||
                  (dec.cls == mcid_pkg::CLS_LIT && dec.op[3:1] == 3'h6);
  assign ax = dec.cls == mcid_pkg::CLS_LIT ? dec.lit : fval;
  assign sum = {1'b0, ax} + {1'b0, is_sub ? ~acc : acc} + {8'h00, is_sub};
  assign nib = {1'b0, ax[3:0]} + {1'b0, is_sub ? ~acc[3:0] : acc[3:0]} +
               {4'h0, is_sub};
  assign prog_addr = pc;
  assign port_latch = latch;
  assign sleeping = state == mcid_pkg::MCID_SLEEP;

  // operand read, special locations first
  always_comb
  begin
    if (dec.f == mcid_pkg::F_TIMER)
      fval = tmr;
    else if (dec.f == mcid_pkg::F_PCL)
      fval = pc[7:0];
    else if (dec.f == mcid_pkg::F_STATUS)
      fval = status;
    else if (dec.f == mcid_pkg::F_PORT)
      fval = pin_s2;
    else if (dec.f == mcid_pkg::F_PROGRAM_COUNTER_UPPER_LATCH)
      fval = {3'h0, program_counter_upper_latch};
    else
      fval = ram[ridx];
  end

  // ---------------------------------------------------------------
  // execution next-state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_pc = pc;
    next_acc = acc;
    next_status = status;
    next_program_counter_upper_latch = program_counter_upper_latch;
    next_latch = latch;
    next_sp = sp;
    next_irq_act = irq_act;
    push = 1'b0;
    push_val = pc;
    ram_we = 1'b0;
    res = 8'h00;
    wr_f = 1'b0;
    wr_acc = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    c_val = sum[8];
    // timer ticks every cycle or on prescaler wrap
    next_pre = pre + 8'h01;
    if (!ctrl[mcid_pkg::CTRL_PS_TMR] || pre == 8'hff)
      next_tmr = tmr + 8'h01;
    else
      next_tmr = tmr;
    case (state)
      mcid_pkg::MCID_FLUSH:
        next_state = mcid_pkg::MCID_EXEC; // second cycle is a no-op
      mcid_pkg::MCID_SLEEP:
        if (irq_s2)
          next_state = mcid_pkg::MCID_EXEC;
      default:
        if (run && take_irq)
        begin
          push = 1'b1;
          push_val = pc;
          next_pc = mcid_pkg::IRQ_VECTOR;
          next_irq_act = 1'b1;
          next_state = mcid_pkg::MCID_FLUSH;
        end
        else if (run)
        begin
          next_pc = pc + 13'h0001;
          case (dec.cls)
            mcid_pkg::CLS_BYTE:
            begin
              wr_f = dec.dest;
              wr_acc = !dec.dest;
              upd_z = 1'b1;
              case (dec.op)
                4'h0:
                begin
                  upd_z = 1'b0;
                  wr_acc = 1'b0;
                  res = acc;
                  if (!dec.dest)
                  begin
                    // fixed words, nop ignores its free bits
                    if (dec.f == mcid_pkg::FIX_RETURN ||
                        dec.f == mcid_pkg::FIX_RETFIE)
                    begin
                      next_pc = stack[sp - 3'h1];
                      next_sp = sp - 3'h1;
                      next_state = mcid_pkg::MCID_FLUSH;
                      if (dec.f == mcid_pkg::FIX_RETFIE)
                        next_irq_act = 1'b0;
                    end
                    else if (dec.f == mcid_pkg::FIX_SLEEP)
                    begin
                      next_status[mcid_pkg::ST_TO] = 1'b1;
                      next_status[mcid_pkg::ST_PD] = 1'b0;
                      next_state = mcid_pkg::MCID_SLEEP;
                    end
                    else if (dec.f == mcid_pkg::FIX_CLRWDT)
                    begin
                      next_status[mcid_pkg::ST_TO] = 1'b1;
                      next_status[mcid_pkg::ST_PD] = 1'b1;
                    end
                  end
                end
                4'h1: res = 8'h00; // clear, low bits free
                4'h2, 4'h7:
                begin
                  res = sum[7:0];
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                end
                4'h3: res = fval - 8'h01;
                4'h4: res = acc | fval;
                4'h5: res = acc & fval;
                4'h6: res = acc ^ fval;
                4'h8: res = fval;
                4'h9: res = ~fval;
                4'ha: res = fval + 8'h01;
                4'hb, 4'hf:
                begin
                  res = dec.op[2] ? fval + 8'h01 : fval - 8'h01;
                  upd_z = 1'b0;
                  if (res == 8'h00)
                  begin
                    next_pc = pc + 13'h0002;
                    next_state = mcid_pkg::MCID_FLUSH;
                  end
                end
                4'hd, 4'hc:
                begin
                  upd_z = 1'b0;
                  upd_c = 1'b1;
                  if (dec.op[0])
                    {c_val, res} = {fval, status[mcid_pkg::ST_C]};
                  else
                    {res, c_val} = {status[mcid_pkg::ST_C], fval};
                end
                default:
                begin
                  upd_z = 1'b0;
                  res = {fval[3:0], fval[7:4]};
                end
              endcase
            end
            mcid_pkg::CLS_BIT:
            begin
              res = fval;
              if (!dec.op[3])
              begin
                res[dec.bitpos] = dec.op[2];
                wr_f = 1'b1;
              end
              else if (fval[dec.bitpos] == dec.op[2])
              begin
                next_pc = pc + 13'h0002;
                next_state = mcid_pkg::MCID_FLUSH;
              end
            end
            mcid_pkg::CLS_CTRL:
            begin
              if (!dec.op[3])
              begin
                push = 1'b1; // call saves next address
                push_val = pc + 13'h0001;
                next_sp = sp + 3'h1;
              end
              next_pc = {program_counter_upper_latch[4:3], dec.target};
              next_state = mcid_pkg::MCID_FLUSH;
            end
            default:
            begin
              res = dec.lit;
              wr_acc = 1'b1;
              if (dec.op[3:2] == 2'h1)
              begin
                next_pc = stack[sp - 3'h1];
                next_sp = sp - 3'h1;
                next_state = mcid_pkg::MCID_FLUSH;
              end
              else if (dec.op[3:2] == 2'h3)
              begin
                res = sum[7:0];
                upd_z = 1'b1;
                upd_c = 1'b1;
                upd_dc = 1'b1;
              end
              else if (dec.op[3:2] == 2'h2)
              begin
                upd_z = 1'b1;
                case (dec.op[1:0])
                  2'h0: res = acc | dec.lit;
                  2'h1: res = acc & dec.lit;
                  2'h2: res = acc ^ dec.lit;
                  default:
                  begin
                    upd_z = 1'b0;
                    wr_acc = 1'b0;
                  end
                endcase
              end
            end
          endcase
          if (push && dec.cls == mcid_pkg::CLS_BYTE)
            next_sp = sp;
        end
    endcase
    if (take_irq && run && state == mcid_pkg::MCID_EXEC)
      next_sp = sp + 3'h1;
    // commit the result byte
    if (wr_acc)
      next_acc = res;
    if (wr_f)
    begin
      if (dec.f == mcid_pkg::F_TIMER)
      begin
        next_tmr = res;
        if (ctrl[mcid_pkg::CTRL_PS_TMR])
          next_pre = 8'h00;
      end
      else if (dec.f == mcid_pkg::F_PCL)
      begin
        next_pc = {program_counter_upper_latch, res};
        next_state = mcid_pkg::MCID_FLUSH;
      end
      else if (dec.f == mcid_pkg::F_STATUS)
        next_status = {res[7:5], status[4:3], res[2:0]};
      else if (dec.f == mcid_pkg::F_PORT)
        next_latch = res;
      else if (dec.f == mcid_pkg::F_PROGRAM_COUNTER_UPPER_LATCH)
        next_program_counter_upper_latch = res[4:0];
      else
        ram_we = 1'b1;
    end
    if (upd_z)
      next_status[mcid_pkg::ST_Z] = res == 8'h00;
    if (upd_c)
      next_status[mcid_pkg::ST_C] = c_val;
    if (upd_dc)
      next_status[mcid_pkg::ST_DC] = nib[4];
  end

  // core registers
  always_ff @(posedge aclk)
  begin
    pin_s1 <= port_pins;
    pin_s2 <= pin_s1;
    irq_s1 <= irq_pin;
    irq_s2 <= irq_s1;
    if (!aresetn)
    begin
      state <= mcid_pkg::MCID_EXEC;
      pc <= 13'h0000;
      acc <= 8'h00;
      status <= mcid_pkg::STATUS_RESET;
      program_counter_upper_latch <= 5'h00;
      latch <= 8'h00;
      tmr <= 8'h00;
      pre <= 8'h00;
      sp <= 3'h0;
      irq_act <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pc <= next_pc;
      acc <= next_acc;
      status <= next_status;
      program_counter_upper_latch <= next_program_counter_upper_latch;
      latch <= next_latch;
      tmr <= next_tmr;
      pre <= next_pre;
      sp <= next_sp;
      irq_act <= next_irq_act;
    end
  end

  // memories, no reset
  always_ff @(posedge aclk)
  begin
    if (push)
      stack[sp] <= push_val;
    if (ram_we)
      ram[ridx] <= res;
  end

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane, next_w_lane;
  logic [2:0] next_ctrl;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;

  // write and read channel next values
  always_comb
  begin
    next_aw_held = aw_held || (awvalid && awready);
    next_aw_addr = awvalid && awready ? awaddr : aw_addr;
    next_w_held = w_held || (wvalid && wready);
    next_w_byte = wvalid && wready ? wdata[7:0] : w_byte;
    next_w_lane = wvalid && wready ? wstrb[0] : w_lane;
    next_ctrl = ctrl;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    if (aw_held && w_held)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mcid_pkg::RESP_OKAY;
      if (aw_addr[7:2] == mcid_pkg::REG_CTRL[7:2])
      begin
        if (w_lane)
          next_ctrl = w_byte[2:0];
      end
      else if (aw_addr[7:2] != mcid_pkg::REG_CORE[7:2] &&
               aw_addr[7:2] != mcid_pkg::REG_FLAGS[7:2])
        next_bresp = mcid_pkg::RESP_SLVERR;
    end
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = mcid_pkg::RESP_OKAY;
      if (araddr[7:2] == mcid_pkg::REG_CTRL[7:2])
        next_rdata = {29'h0000_0000, ctrl};
      else if (araddr[7:2] == mcid_pkg::REG_CORE[7:2])
        next_rdata = {3'h0, pc, 6'h00, state, acc};
      else if (araddr[7:2] == mcid_pkg::REG_FLAGS[7:2])
        next_rdata = {8'h00, pre, tmr, status};
      else
      begin
        next_rdata = 32'h0000_0000;
        next_rresp = mcid_pkg::RESP_SLVERR;
      end
    end
  end

  // bus registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      ctrl <= mcid_pkg::CTRL_RESET;
      bvalid <= 1'b0;
      bresp <= mcid_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= mcid_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane <= next_w_lane;
      ctrl <= next_ctrl;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  irq_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && take_irq && state == mcid_pkg::MCID_EXEC) |=>
    stack[sp - 3'h1] == $past(pc) && acc == $past(acc) &&
    pc == mcid_pkg::IRQ_VECTOR) else $error("interrupt entry wrong");
  shared_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ram_we && dec.f >= mcid_pkg::SHARED_BASE) |-> ridx[8:7] == 2'h0)
    else $error("shared byte banked");
  bit_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && dec.cls == mcid_pkg::CLS_BIT && dec.op[3] &&
     fval[dec.bitpos] == dec.op[2]) |=>
    state == mcid_pkg::MCID_FLUSH && status == $past(status) ##1
    pc == $past(pc, 2) + 13'h0002) else $error("bit skip wrong");
  branch_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && dec.cls == mcid_pkg::CLS_CTRL) |=>
    state == mcid_pkg::MCID_FLUSH ##1
    state == mcid_pkg::MCID_EXEC &&
    pc == {$past(program_counter_upper_latch[4:3], 2), $past(dec.target, 2)})
    else $error("branch timing wrong");
  lit_return_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && dec.cls == mcid_pkg::CLS_LIT && dec.op[3:2] == 2'h1) |=>
    acc == $past(dec.lit) && state == mcid_pkg::MCID_FLUSH &&
    status == $past(status)) else $error("literal return wrong");
  standby_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && prog_word == {7'h00, mcid_pkg::FIX_SLEEP}) |=>
    sleeping && status[mcid_pkg::ST_TO] && !status[mcid_pkg::ST_PD])
    else $error("standby entry wrong");
  presc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_f && dec.f == mcid_pkg::F_TIMER && ctrl[mcid_pkg::CTRL_PS_TMR]) |=>
    pre == 8'h00) else $error("prescaler not cleared");
  lit_logic_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (exec && dec.cls == mcid_pkg::CLS_LIT && dec.op == 4'h9) |=>
    acc == ($past(acc) & $past(dec.lit)) &&
    status[mcid_pkg::ST_Z] == (acc == 8'h00) &&
    status[1:0] == $past(status[1:0])) else $error("literal and wrong");
endmodule // mcid_core
`default_nettype wire

// *** mcid_progmem.sv ***
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// program memory model: word answered in the same cycle
// ---------------------------------------------------------------
module mcid_progmem (
  // fetch port
  input wire logic [12:0] prog_addr,
  output logic [13:0] prog_word
);
  logic [13:0] mem [0:15]; // small program store, loaded by the bench
  // beyond the store a fixed filler word, never an unknown
  assign prog_word = (prog_addr < 13'h0010) ? mem[prog_addr[3:0]] : 14'h0000;
endmodule // mcid_progmem
`default_nettype wire

// *** mcid_core_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module mcid_core_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, irq_pin;
  logic awready, wready, bvalid, arready, rvalid, sleeping;
  logic [7:0] awaddr, araddr, port_latch, port_pins;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [12:0] prog_addr;
  logic [13:0] prog_word;
  int failures, tests_run, i;
  // test program: literal ops, add, skip, call, return, standby
  logic [13:0] prog [0:10] = '{14'h33f0, 14'h393c, 14'h3aff, 14'h3810, 14'h3e21,
    14'h1c03, 14'h2808, 14'h200a, 14'h0063, 14'h0000, 14'h3755};
  // second program: jump past the vector, move, rotate, xor, port rmw, timer write,
  // two decrement skips, bit set on the port, standby; the vector word loops on itself
  logic [13:0] prog2 [0:15] = '{14'h2805, 14'h0000, 14'h0000, 14'h0000, 14'h2804,
    14'h3081, 14'h00a0, 14'h0da0, 14'h0620, 14'h0886, 14'h0081, 14'h0ba0, 14'h0ba0,
    14'h3000, 14'h1786, 14'h0063};
  // ---------------------------------------------------------------
  // design, program memory and clock
  // ---------------------------------------------------------------
  mcid_core dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .prog_addr, .prog_word,
    .port_pins, .port_latch, .irq_pin, .sleeping);
  mcid_progmem pm (.prog_addr, .prog_word);
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n > 100)
    begin
      failures++;
      print_verdict();
    end
  endtask
  // ---------------------------------------------------------------
  // register bus master tasks
  // ---------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    logic ta, tw, a1, w1, got;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    {ta, tw, got, n} = '0;
    while (!(ta && tw))
    begin
      @(negedge aclk);
      a1 = awvalid && awready;
      w1 = wvalid && wready;
      @(posedge aclk);
      if (a1) awvalid <= 1'b0;
      if (w1) wvalid <= 1'b0;
      ta |= a1;
      tw |= w1;
      tmo(++n);
    end
    while (!got)
    begin
      @(negedge aclk);
      got = bvalid;
      rs = bresp;
      @(posedge aclk);
      tmo(++n);
    end
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    logic got, a1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    {got, n} = '0;
    while (!got)
    begin
      @(negedge aclk);
      a1 = arvalid && arready;
      got = rvalid;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      // address released only after the edge that takes it
      if (a1) arvalid <= 1'b0;
      tmo(++n);
    end
    rready <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // wait for standby, sampled away from the launching edge
  task automatic wait_sleep;
    int n;
    while (sleeping !== 1'b1)
    begin
      @(negedge aclk);
      tmo(++n);
    end
    chk({31'h0, sleeping}, 32'h0000_0001);
  endtask
  // literal ops, add, skip, call, literal return, standby
  task automatic basic_scn;
    for (i = 0; i < 16; i++)
      pm.mem[i] = (i < 11) ? prog[i] : 14'h0000;
    axr(8'h00, d, r);
    chk(d, 32'h0000_0000); // core halted after reset
    axr(8'h08, d, r);
    chk({24'h0, d[7:0]}, 32'h0000_0018); // status reset value
    axr(8'h0c, d, r);
    chk({30'h0, r}, 32'h0000_0002); // unmapped read refused
    chk(d, 32'h0000_0000); // unmapped read data
    axw(8'h0c, 32'h0000_0001, r);
    chk({30'h0, r}, 32'h0000_0002); // unmapped write refused
    axw(8'h00, 32'h0000_0001, r);
    chk({30'h0, r}, 32'h0000_0000); // run accepted
    wait_sleep();
    axr(8'h04, d, r);
    chk({24'h0, d[7:0]}, 32'h0000_0055);
    chk({19'h0, d[28:16]}, 32'h0000_0009);
    axr(8'h08, d, r);
    chk({29'h0, d[2:0]}, 32'h0000_0007);
  endtask
  // mid-run reset, register ops, port rmw, timer write, interrupt out of standby
  task automatic irq_port_scn;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 16; i++)
      pm.mem[i] = prog2[i];
    axr(8'h04, d, r);
    chk(d, 32'h0000_0000); // pc, state and accumulator back to reset
    axw(8'h00, 32'h0000_0007, r);
    chk({30'h0, r}, 32'h0000_0000); // run, gie, prescaler on timer
    wait_sleep();
    @(posedge aclk);
    irq_pin <= 1'b1;
    repeat (12) @(posedge aclk);
    axr(8'h04, d, r);
    chk({24'h0, d[7:0]}, 32'h0000_0083);
    chk({19'h0, d[28:16]}, {19'h0, mcid_pkg::IRQ_VECTOR});
    axr(8'h08, d, r);
    chk({24'h0, d[7:0]}, 32'h0000_0011);
    chk({24'h0, port_latch}, 32'h0000_00a5);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, irq_pin} = '0;
    {awaddr, araddr, wdata, wstrb, port_pins, failures, tests_run} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wstrb <= 4'hf;
    port_pins <= 8'h25;
    basic_scn();
    irq_port_scn();
    print_verdict();
  end
endmodule // mcid_core_tb
`default_nettype wire
